// ==== testbench/ethernet_descriptor_dma_bench.sv ====
`timescale 1ns/1ps
`include "edma_defs.svh"
module ethernet_descriptor_dma_bench;
   import edma_pkg::*;
   logic        ref_clk, rst_n, reg_wr, reg_rd, slow, tx_fifo_ready, rx_missed;
   logic [31:0] reg_addr, reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, tx_fifo_data;
   logic        mem_req, mem_we, mem_ack, tx_fifo_push, tx_fifo_end, rx_fifo_pop, ctrl_reset;
   logic [15:0] rx_fifo_status;
   word_t       rxw [0:3];
   word_t       txq [$];
   int          rx_i = 4;
   int          ends, miscompares, tests_run;
   wire         rx_fifo_burst_ok = rx_i < 4;
   wire         rx_fifo_end = rx_i == 3;
   wire  [31:0] rx_fifo_data = rx_i < 4 ? rxw[rx_i] : ~rxw[3];

   ethernet_dma_engine dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
      .tx_fifo_ready, .tx_fifo_data, .tx_fifo_push, .tx_fifo_end, .rx_fifo_burst_ok,
      .rx_fifo_data, .rx_fifo_end, .rx_fifo_status, .rx_fifo_pop, .rx_missed, .ctrl_reset);
   sys_memory_model mem (.ref_clk, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata,
      .mem_ack, .mem_rdata);

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (rx_fifo_pop) rx_i <= rx_i + 1;
      if (tx_fifo_push) txq.push_back(tx_fifo_data);
      if (tx_fifo_push && tx_fifo_end) ends <= ends + 1;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input word_t seen, input word_t exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input word_t a, input word_t d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input word_t a, output word_t v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic wait_done(input int idx);
      int n = 0;
      while (mem.ram[idx][31] !== 1'b0 && n < 5000) begin
         @(posedge ref_clk);
         n++;
      end
      if (mem.ram[idx][31] !== 1'b0) begin
         miscompares++;
         results();
      end else begin
         repeat (60) @(posedge ref_clk);
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic regs_test();
      word_t v;
      for (int a = 0; a <= 32'h50; a += 4) begin
         rd(32'hFFFFFD00 + a, v);
         check(v, 32'h0);
      end
      // list bases carry no reserved bits, so any pattern is legal there
      for (int a = 32'h0C; a <= 32'h50; a += 4)
         if (!(a inside {[32'h14:32'h30]})) wr(32'hFFFFFD00 + a, 32'h5A5A0000 + a);
      for (int a = 32'h0C; a <= 32'h50; a += 4) begin
         rd(32'hFFFFFD00 + a, v);
         check(v, a <= 32'h10 ? 32'h5A5A0000 + a : 32'h0);
      end
   endtask
   task automatic missed_test();
      word_t v;
      repeat (3) begin
         rx_missed <= 1'b1;
         @(posedge ref_clk);
         rx_missed <= 1'b0;
         @(posedge ref_clk);
      end
      rd(`A_MISSED_COUNT, v);
      check(v, 32'h3);
      rd(`A_MISSED_COUNT, v);
      check(v, 32'h0);
      wr(`A_EVENT_STATUS, 32'h0);
      rd(`A_EVENT_STATUS, v);
      check(v & 32'h10, 32'h10);
      wr(`A_EVENT_STATUS, 32'h10);
      rd(`A_EVENT_STATUS, v);
      check(v & 32'h10, 32'h0);
   endtask
   task automatic tx_test();
      word_t v;
      for (int i = 0; i < 4; i++) begin
         mem.ram[8'h80 + i] = 32'hA0000000 + i;
         mem.ram[8'h90 + i] = 32'hB0000000 + i;
      end
      mem.ram[8'h40] = 32'h80000000;
      mem.ram[8'h41] = 32'h10;
      mem.ram[8'h42] = 32'h10000200;
      mem.ram[8'h44] = 32'hE0000000;
      mem.ram[8'h45] = 32'h10;
      mem.ram[8'h46] = 32'h10000240;
      slow <= 1'b1;
      wr(`A_TX_LIST_BASE, 32'h10000100);
      wr(`A_TX_START, 32'h1);
      wait_done(8'h44);
      check(txq.size(), 32'h8);
      for (int i = 0; i < 8; i++)
         check(txq[i], i < 4 ? 32'hA0000000 + i : 32'hB0000000 + i - 4);
      check(ends, 32'h1);
      check(mem.ram[8'h40] & 32'h80000000, 32'h0);
      rd(`A_EVENT_STATUS, v);
      check(v & 32'h0A, 32'h0A);
      rd(`A_TX_START, v);
      check(v & 32'h1, 32'h0);
      rd(`A_TX_BUF_PTR, v);
      check(v, 32'h10000250);
      rd(`A_TX_DESC_PTR, v);
      check(v, 32'h10000100);
   endtask
   task automatic rx_test();
      word_t v;
      wr(`A_MODE_CTRL, 32'h1);
      #1 check({31'h00000000, ctrl_reset}, 32'h1);
      repeat (2) @(posedge ref_clk);
      rd(`A_TX_LIST_BASE, v);
      check(v, 32'h0);
      for (int i = 0; i < 4; i++) rxw[i] = 32'hC0000000 + i;
      mem.ram[8'h60] = 32'hC0000000;
      mem.ram[8'h61] = 32'h40;
      mem.ram[8'h62] = 32'h10000300;
      slow <= 1'b0;
      rx_fifo_status <= 16'hA5C3;
      wr(`A_COPY_ENABLE, 32'h1);
      wr(`A_RX_LIST_BASE, 32'h10000180);
      rx_i <= 0;
      wr(`A_RX_START, 32'h1);
      wait_done(8'h60);
      for (int i = 0; i < 4; i++) check(mem.ram[8'hC0 + i], 32'hC0000000 + i);
      check(mem.ram[8'h60], 32'h6000A5C3);
      check({16'h0000, mem.ram[8'h61][31:16]}, 32'h4);
      rd(`A_EVENT_STATUS, v);
      check(v & 32'h1, 32'h1);
      rd(`A_RX_BUF_PTR, v);
      check(v, 32'h10000310);
      rd(`A_RX_DESC_PTR, v);
      check(v, 32'h10000180);
   endtask
   initial begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 32'h0;
      reg_wdata = 32'h0;
      slow = 1'b0;
      tx_fifo_ready = 1'b1;
      rx_missed = 1'b0;
      rx_fifo_status = 16'h0;
      ends = 0;
      for (int i = 0; i < 4; i++) rxw[i] = 32'h0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      regs_test();
      missed_test();
      tx_test();
      rx_test();
      results();
   end
endmodule

// ==== testbench/ethernet_descriptor_dma_checker.sv ====
`timescale 1ns/1ps
`include "edma_defs.svh"
module edma_port_checker (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic        mem_ack,
   input wire logic        tx_fifo_push,
   input wire logic        tx_fifo_end,
   input wire logic        rx_fifo_pop,
   input wire logic        rx_missed,
   input wire logic        ctrl_reset
);
   // ----------------------------------------
   // beat count inside a burst
   // ----------------------------------------
   logic [1:0] beat_ff;
   wire        rd_miss = reg_rd && reg_addr == `A_MISSED_COUNT && !rx_missed;
   wire        wr_ev   = reg_wr && reg_addr == `A_EVENT_STATUS && reg_wdata[`EV_MISSED];
   wire        rd_ev   = reg_rd && reg_addr == `A_EVENT_STATUS && !rx_missed;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) beat_ff <= 2'h0;
      else if (!mem_req) beat_ff <= 2'h0;
      else if (mem_ack) beat_ff <= beat_ff + 2'h1;
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   swr_pulse_a: assert property (reg_wr && reg_addr == `A_MODE_CTRL && reg_wdata[0]
      |=> ctrl_reset) else $error("soft reset pulse missing");
   swr_single_a: assert property (ctrl_reset |=> !ctrl_reset)
      else $error("soft reset pulse too long");
   burst_hold_a: assert property (mem_req && !mem_ack && !ctrl_reset
      |=> mem_req && $stable(mem_addr) && $stable(mem_we)) else $error("burst not held");
   burst_four_a: assert property (mem_req && mem_ack && beat_ff != 2'h3 && !ctrl_reset
      |=> mem_req) else $error("burst ended before four beats");
   burst_align_a: assert property (mem_req |-> mem_addr[3:0] == 4'h0)
      else $error("burst start not on sixteen bytes");
   push_src_a: assert property (tx_fifo_push |-> $past(mem_ack) && !$past(mem_we))
      else $error("fifo push without memory read beat");
   end_push_a: assert property (tx_fifo_end |-> tx_fifo_push)
      else $error("frame end without push");
   miss_clear_a: assert property (rd_miss ##1 rd_miss |=> reg_rdata == 32'h0)
      else $error("missed count not cleared by read");
   w1c_clear_a: assert property (wr_ev && !rx_missed ##1 rd_ev
      |=> !reg_rdata[`EV_MISSED]) else $error("status bit not cleared by one");
   hole_zero_a: assert property (reg_rd && reg_addr == 32'hFFFFFD34
      |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
   tx_end_c: cover property (tx_fifo_push && tx_fifo_end);
   rx_pop_c: cover property (rx_fifo_pop);
   swr_c: cover property (ctrl_reset);
endmodule

bind ethernet_dma_engine edma_port_checker chk (
   .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mem_req,
   .mem_we, .mem_addr, .mem_ack, .tx_fifo_push, .tx_fifo_end, .rx_fifo_pop, .rx_missed,
   .ctrl_reset
);

// ==== testbench/sys_memory_model.sv ====
`timescale 1ns/1ps
module sys_memory_model (
   input  wire logic        ref_clk,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output      logic        mem_ack,
   output      logic [31:0] mem_rdata
);
   // ----------------------------------------
   // external memory, address aliased
   // ----------------------------------------
   logic [31:0] ram [0:255]; // external memory only
   logic [1:0]  beat;
   logic [2:0]  gap;
   wire  [7:0]  idx = mem_addr[9:2] + {6'h00, beat};
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 32'h0;
      beat = 2'h0;
      gap = 3'h0;
   end
   // idle data bus toggles so stale words never look valid
   always @(posedge ref_clk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!mem_req) begin
         beat <= 2'h0;
         gap <= 3'h0;
      end else if (mem_ack) gap <= 3'h0;
      else if (gap < (slow ? 3'h4 : 3'h1)) gap <= gap + 3'h1;
      else begin
         mem_ack <= 1'b1;
         if (mem_we) ram[idx] <= mem_wdata;
         else mem_rdata <= ram[idx];
         beat <= beat + 2'h1;
      end
   end
endmodule

// ==== verilog/edma_defs.svh ====
`ifndef EDMA_DEFS_SVH
`define EDMA_DEFS_SVH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define A_MODE_CTRL      32'hFFFFFD00
`define A_TX_START       32'hFFFFFD04
`define A_RX_START       32'hFFFFFD08
`define A_TX_LIST_BASE   32'hFFFFFD0C
`define A_RX_LIST_BASE   32'hFFFFFD10
`define A_EVENT_STATUS   32'hFFFFFD14
`define A_EVENT_IRQ_EN   32'hFFFFFD18
`define A_COPY_ENABLE    32'hFFFFFD1C
`define A_MISSED_COUNT   32'hFFFFFD20
`define A_TX_FIFO_THR    32'hFFFFFD24
`define A_FIFO_DEPTH     32'hFFFFFD28
`define A_RECEIVER_CTRL  32'hFFFFFD2C
`define A_DMA_OP_CTRL    32'hFFFFFD30
`define A_RX_BUF_PTR     32'hFFFFFD40
`define A_RX_DESC_PTR    32'hFFFFFD44
`define A_TX_BUF_PTR     32'hFFFFFD4C
`define A_TX_DESC_PTR    32'hFFFFFD50

// ---------------------------------------------------------------
// reset values and fields
// ---------------------------------------------------------------
`define RST_WORD         32'h00000000
`define SWR_BIT          0
`define REQ_BIT          0
`define EV_RX_FRAME      0
`define EV_TX_FRAME      1
`define EV_RX_EMPTY      2
`define EV_TX_EMPTY      3
`define EV_MISSED        4
`define EV_W             5
`define RCR_CONT_BIT     0
`define COPY_RX_BIT      0

// ---------------------------------------------------------------
// descriptor layout: word0 status, word1 length, word2 buffer
// ---------------------------------------------------------------
`define D_OWN            31
`define D_LIST_END       30
`define D_FRAME_END      29
`define D_LEN_MSB        15
`define D_CNT_LSB        16
`define BURST_BYTES      32'h00000010
`define BEAT_LAST        2'h3
`define LEN_W            16

`endif

// ==== verilog/edma_pkg.sv ====
package edma_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_DESC, ST_DATA, ST_BACK} engine_state_e;
   typedef logic [31:0] word_t;
   localparam logic CH_TX = 1'b0;
   localparam logic CH_RX = 1'b1;
endpackage

// ==== verilog/ethernet_dma_engine.sv ====
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "edma_defs.svh"
module ethernet_dma_engine
   import edma_pkg::*;
#(
   parameter int MISS_W = 16
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [31:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output      logic [31:0] reg_rdata,
   output      logic        mem_req,
   output      logic        mem_we,
   output      logic [31:0] mem_addr,
   output      logic [31:0] mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   input  wire logic        tx_fifo_ready,
   output      logic [31:0] tx_fifo_data,
   output      logic        tx_fifo_push,
   output      logic        tx_fifo_end,
   input  wire logic        rx_fifo_burst_ok,
   input  wire logic [31:0] rx_fifo_data,
   input  wire logic        rx_fifo_end,
   input  wire logic [15:0] rx_fifo_status,
   output      logic        rx_fifo_pop,
   input  wire logic        rx_missed,
   output      logic        ctrl_reset
);
   generate
      if (MISS_W < 1 || MISS_W > 32) begin : g_bad
         $error("MISS_W must be 1..32");
      end
   endgenerate

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic              swr_ff;
   word_t             tx_base_ff, rx_base_ff, irq_en_ff, copy_en_ff;
   word_t             thr_ff, depth_ff, rcr_ff, opctl_ff, rdata_ff;
   logic [`EV_W-1:0]  event_ff;
   logic [1:0]        run_ff, have_ff;
   word_t             dptr_ff [2];
   word_t             bptr_ff [2];
   logic [`LEN_W-1:0] left_ff [2];
   word_t             desc_ff [2][4];
   logic [MISS_W-1:0] miss_cnt;

   wire wr_mode  = reg_wr && reg_addr == `A_MODE_CTRL;
   wire wr_txs   = reg_wr && reg_addr == `A_TX_START;
   wire wr_rxs   = reg_wr && reg_addr == `A_RX_START;
   wire wr_ev    = reg_wr && reg_addr == `A_EVENT_STATUS;
   wire rd_miss  = reg_rd && reg_addr == `A_MISSED_COUNT;
   wire start_tx = wr_txs && reg_wdata[`REQ_BIT];
   wire start_rx = wr_rxs && reg_wdata[`REQ_BIT];
   word_t rd_mux;

   // unmapped and write-only reads answer zero
   always_comb begin
      case (reg_addr)
         `A_MODE_CTRL:     rd_mux = `RST_WORD;
         `A_TX_START:      rd_mux = {31'h00000000, run_ff[CH_TX]};
         `A_RX_START:      rd_mux = {31'h00000000, run_ff[CH_RX]};
         `A_TX_LIST_BASE:  rd_mux = tx_base_ff;
         `A_RX_LIST_BASE:  rd_mux = rx_base_ff;
         `A_EVENT_STATUS:  rd_mux = {{(32-`EV_W){1'b0}}, event_ff};
         `A_EVENT_IRQ_EN:  rd_mux = irq_en_ff;
         `A_COPY_ENABLE:   rd_mux = copy_en_ff;
         `A_MISSED_COUNT:  rd_mux = 32'(miss_cnt);
         `A_TX_FIFO_THR:   rd_mux = thr_ff;
         `A_FIFO_DEPTH:    rd_mux = depth_ff;
         `A_RECEIVER_CTRL: rd_mux = rcr_ff;
         `A_DMA_OP_CTRL:   rd_mux = opctl_ff;
         `A_RX_BUF_PTR:    rd_mux = bptr_ff[CH_RX];
         `A_RX_DESC_PTR:   rd_mux = dptr_ff[CH_RX];
         `A_TX_BUF_PTR:    rd_mux = bptr_ff[CH_TX];
         `A_TX_DESC_PTR:   rd_mux = dptr_ff[CH_TX];
         default:          rd_mux = `RST_WORD;
      endcase
   end

   // swr_ff is a one-cycle pulse; it also drives the controller reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) swr_ff <= 1'b0;
      else swr_ff <= wr_mode && reg_wdata[`SWR_BIT];
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) rdata_ff <= `RST_WORD;
      else if (reg_rd) rdata_ff <= rd_mux;
   end

   // plain read/write storage; mode settings are only safe after reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n || swr_ff) begin
         tx_base_ff <= `RST_WORD;
         rx_base_ff <= `RST_WORD;
         irq_en_ff  <= `RST_WORD;
         copy_en_ff <= `RST_WORD;
         thr_ff     <= `RST_WORD;
         depth_ff   <= `RST_WORD;
         rcr_ff     <= `RST_WORD;
         opctl_ff   <= `RST_WORD;
      end else if (reg_wr) begin
         case (reg_addr)
            `A_TX_LIST_BASE:  tx_base_ff <= reg_wdata;
            `A_RX_LIST_BASE:  rx_base_ff <= reg_wdata;
            `A_EVENT_IRQ_EN:  irq_en_ff  <= reg_wdata;
            `A_COPY_ENABLE:   copy_en_ff <= reg_wdata;
            `A_TX_FIFO_THR:   thr_ff     <= reg_wdata;
            `A_FIFO_DEPTH:    depth_ff   <= reg_wdata;
            `A_RECEIVER_CTRL: rcr_ff     <= reg_wdata;
            `A_DMA_OP_CTRL:   opctl_ff   <= reg_wdata;
            default:          ;
         endcase
      end
   end

   missed_counter #(
      .CNT_W (MISS_W)
   ) u_miss (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .soft_clr (swr_ff),
      .inc      (rx_missed),
      .rd_clr   (rd_miss),
      .count    (miss_cnt)
   );

   // ---------------------------------------------------------------
   // burst engine
   // ---------------------------------------------------------------
   engine_state_e st_ff;
   logic          ch_ff, fend_ff, mreq_ff, mwe_ff, pop_ff, push_ff, tend_ff;
   logic [1:0]    beat_ff;
   word_t         maddr_ff, mwdata_ff, tdata_ff;
   logic [15:0]   rx_stat_ff, rx_cnt_ff;

   wire rx_go   = run_ff[CH_RX] && (!have_ff[CH_RX] || rx_fifo_burst_ok);
   wire tx_go   = run_ff[CH_TX] && (!have_ff[CH_TX] || tx_fifo_ready);
   // alternate when both are ready so neither channel starves
   wire pick    = rx_go && (!tx_go || ch_ff == CH_TX);
   wire go      = st_ff == ST_IDLE && (rx_go || tx_go) && !swr_ff;
   wire ack_end = mem_ack && beat_ff == `BEAT_LAST;
   wire rx_take = left_ff[CH_RX] != '0 && !fend_ff;
   wire tx_fend = desc_ff[CH_TX][0][`D_FRAME_END];
   wire owned   = desc_ff[ch_ff][0][`D_OWN];
   wire [`LEN_W-1:0] buf_words = `LEN_W'((desc_ff[ch_ff][1][`D_LEN_MSB:0] + 17'h00003) >> 2);
   wire buf_done = ch_ff == CH_RX ? (fend_ff || left_ff[CH_RX] == '0)
                                  : left_ff[CH_TX] <= `LEN_W'(1);
   wire frame_done = ch_ff == CH_RX ? fend_ff : tx_fend;
   wire [31:0] stat_w0 = ch_ff == CH_TX ? desc_ff[CH_TX][0] & ~(32'h1 << `D_OWN)
                       : {1'b0, desc_ff[CH_RX][0][`D_LIST_END], fend_ff, 13'h0000,
                          copy_en_ff[`COPY_RX_BIT] ? rx_stat_ff : 16'h0000};
   wire [31:0] stat_w1 = ch_ff == CH_TX ? desc_ff[CH_TX][1]
                       : {rx_cnt_ff, desc_ff[CH_RX][1][`D_LEN_MSB:0]};
   wire [31:0] back_w [4];
   assign back_w[0] = stat_w0;
   assign back_w[1] = stat_w1;
   assign back_w[2] = desc_ff[ch_ff][2];
   assign back_w[3] = desc_ff[ch_ff][3];
   wire [31:0] next_d  = desc_ff[ch_ff][0][`D_LIST_END] ? (ch_ff ? rx_base_ff : tx_base_ff)
                                                       : dptr_ff[ch_ff] + `BURST_BYTES;
   wire rx_data_go = go && pick && have_ff[CH_RX];
   wire rx_load    = (rx_data_go || (st_ff == ST_DATA && ch_ff == CH_RX && mem_ack
                      && !ack_end)) && rx_take;

   logic [`EV_W-1:0] ev_set;
   always_comb begin
      ev_set = '0;
      ev_set[`EV_MISSED] = rx_missed;
      if (st_ff == ST_DESC && ack_end && !owned)
         ev_set[ch_ff ? `EV_RX_EMPTY : `EV_TX_EMPTY] = 1'b1;
      if (st_ff == ST_BACK && ack_end && frame_done)
         ev_set[ch_ff ? `EV_RX_FRAME : `EV_TX_FRAME] = 1'b1;
   end

   // a new event beats the write-one clear of the same bit
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n || swr_ff) event_ff <= '0;
      else event_ff <= (event_ff & ~(wr_ev ? reg_wdata[`EV_W-1:0] : '0)) | ev_set;
   end

   // a mid-burst software reset drops the bus request; memory must tolerate it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n || swr_ff) begin
         st_ff   <= ST_IDLE;
         ch_ff   <= CH_TX;
         beat_ff <= 2'h0;
         mreq_ff <= 1'b0;
         mwe_ff  <= 1'b0;
         maddr_ff <= `RST_WORD;
      end else begin
         case (st_ff)
            ST_IDLE: if (go) begin
               ch_ff    <= pick;
               beat_ff  <= 2'h0;
               mreq_ff  <= 1'b1;
               mwe_ff   <= have_ff[pick] && pick == CH_RX;
               maddr_ff <= have_ff[pick] ? bptr_ff[pick] : dptr_ff[pick];
               st_ff    <= have_ff[pick] ? ST_DATA : ST_DESC;
            end
            ST_DESC, ST_DATA: if (mem_ack) begin
               beat_ff <= beat_ff + 2'h1;
               if (ack_end) begin
                  beat_ff <= 2'h0;
                  if (st_ff == ST_DATA && buf_done) begin
                     mwe_ff   <= 1'b1;
                     maddr_ff <= dptr_ff[ch_ff];
                     st_ff    <= ST_BACK;
                  end else begin
                     mreq_ff <= 1'b0;
                     st_ff   <= ST_IDLE;
                  end
               end
            end
            ST_BACK: if (mem_ack) begin
               beat_ff <= beat_ff + 2'h1;
               if (ack_end) begin
                  mreq_ff <= 1'b0;
                  mwe_ff  <= 1'b0;
                  st_ff   <= ST_IDLE;
               end
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // channel bookkeeping: run, descriptor copy, pointers, words left
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n || swr_ff) begin
         run_ff  <= 2'b00;
         have_ff <= 2'b00;
         for (int c = 0; c < 2; c++) begin
            dptr_ff[c] <= `RST_WORD;
            bptr_ff[c] <= `RST_WORD;
            left_ff[c] <= '0;
            for (int w = 0; w < 4; w++) desc_ff[c][w] <= `RST_WORD;
         end
      end else begin
         if (st_ff == ST_DESC && mem_ack) desc_ff[ch_ff][beat_ff] <= mem_rdata;
         if (st_ff == ST_DESC && ack_end) begin
            if (owned) begin
               have_ff[ch_ff] <= 1'b1;
               bptr_ff[ch_ff] <= desc_ff[ch_ff][2];
               left_ff[ch_ff] <= buf_words;
            end else begin
               run_ff[ch_ff] <= 1'b0;
            end
         end
         if (st_ff == ST_DATA && mem_ack && ch_ff == CH_TX && left_ff[CH_TX] != '0)
            left_ff[CH_TX] <= left_ff[CH_TX] - 1'b1;
         if (rx_load) left_ff[CH_RX] <= left_ff[CH_RX] - 1'b1;
         if (st_ff == ST_DATA && ack_end)
            bptr_ff[ch_ff] <= bptr_ff[ch_ff] + `BURST_BYTES;
         if (st_ff == ST_BACK && ack_end) begin
            have_ff[ch_ff] <= 1'b0;
            dptr_ff[ch_ff] <= next_d;
            if (ch_ff == CH_RX && fend_ff && !rcr_ff[`RCR_CONT_BIT])
               run_ff[CH_RX] <= 1'b0;
         end
         if (start_tx && !run_ff[CH_TX]) begin
            run_ff[CH_TX]  <= 1'b1;
            have_ff[CH_TX] <= 1'b0;
            dptr_ff[CH_TX] <= tx_base_ff;
         end
         if (start_rx && !run_ff[CH_RX]) begin
            run_ff[CH_RX]  <= 1'b1;
            have_ff[CH_RX] <= 1'b0;
            dptr_ff[CH_RX] <= rx_base_ff;
         end
      end
   end

   // ---------------------------------------------------------------
   // data path toward the FIFOs and memory
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n || swr_ff) begin
         push_ff  <= 1'b0;
         tend_ff  <= 1'b0;
         tdata_ff <= `RST_WORD;
      end else begin
         push_ff <= st_ff == ST_DATA && ch_ff == CH_TX && mem_ack
                    && left_ff[CH_TX] != '0;
         // only on the beat that pushes the last word, never while waiting for it
         tend_ff <= st_ff == ST_DATA && ch_ff == CH_TX && mem_ack
                    && left_ff[CH_TX] == `LEN_W'(1) && tx_fend;
         if (st_ff == ST_DATA && mem_ack) tdata_ff <= mem_rdata;
      end
   end

   // pad beats past the frame end write zero and pop nothing
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n || swr_ff) begin
         pop_ff     <= 1'b0;
         mwdata_ff  <= `RST_WORD;
         fend_ff    <= 1'b0;
         rx_stat_ff <= 16'h0000;
         rx_cnt_ff  <= 16'h0000;
      end else begin
         pop_ff <= rx_load;
         if (rx_data_go || (st_ff == ST_DATA && ch_ff == CH_RX && mem_ack && !ack_end))
            mwdata_ff <= rx_take ? rx_fifo_data : `RST_WORD;
         else if (st_ff == ST_DATA && ack_end && buf_done)
            mwdata_ff <= back_w[0];
         else if (st_ff == ST_BACK && mem_ack && !ack_end)
            mwdata_ff <= back_w[beat_ff + 2'h1];
         if (go && pick == CH_RX && have_ff[CH_RX] == 1'b0) fend_ff <= 1'b0;
         if (rx_load) begin
            rx_cnt_ff <= rx_cnt_ff + 16'h0001;
            if (rx_fifo_end) begin
               fend_ff    <= 1'b1;
               rx_stat_ff <= rx_fifo_status;
            end
         end
         if (st_ff == ST_BACK && ack_end && ch_ff == CH_RX && fend_ff)
            rx_cnt_ff <= 16'h0000;
      end
   end

   assign reg_rdata    = rdata_ff;
   assign mem_req      = mreq_ff;
   assign mem_we       = mwe_ff;
   assign mem_addr     = maddr_ff;
   assign mem_wdata    = mwdata_ff;
   assign tx_fifo_data = tdata_ff;
   assign tx_fifo_push = push_ff;
   assign tx_fifo_end  = tend_ff;
   assign rx_fifo_pop  = pop_ff;
   assign ctrl_reset   = swr_ff;
endmodule

// ==== verilog/missed_counter.sv ====
`timescale 1ns/1ps
`include "edma_defs.svh"
module missed_counter #(
   parameter int CNT_W = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic             soft_clr,
   input  wire logic             inc,
   input  wire logic             rd_clr,
   output      logic [CNT_W-1:0] count
);
   logic [CNT_W-1:0] count_ff;
   wire              at_max = &count_ff;

   generate
      if (CNT_W < 1 || CNT_W > 32) begin : g_bad
         $error("missed_counter width must be 1..32");
      end
   endgenerate

   // a miss landing on the read that clears still counts
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) count_ff <= '0;
      else if (soft_clr) count_ff <= '0;
      else if (rd_clr) count_ff <= {{(CNT_W-1){1'b0}}, inc};
      else if (inc && !at_max) count_ff <= count_ff + 1'b1;
   end

   assign count = count_ff;
endmodule
